// [scc_cfg.svh]
// Purpose: constants of the sensor channel control and status register group
// Assumes: 100 MHz clock, 6-bit register index, 16-bit register data
// Notes: definitions only
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// register offsets
`define SCC_OFS_CHANNEL_CONTROL 6'h02
`define SCC_OFS_NO_OPERATION 6'h03
`define SCC_OFS_FAULT_GENERAL 6'h04
`define SCC_OFS_FAULT_LINES 6'h05

// reset values
`define SCC_RST_CHANNEL_CONTROL 16'h0442
`define SCC_RST_NO_OPERATION 16'h0002

// channel_control fields; channel n sits at n * CH_STRIDE
`define SCC_CTRL_REG_EN_BIT 10
`define SCC_CTRL_CH_STRIDE 5
`define SCC_CTRL_EN_BIT 0
`define SCC_CTRL_ALLOW_BIT 1
`define SCC_CTRL_TRIG_LSB 3
`define SCC_CTRL_RW_MASK 16'h077B

// sync trigger codes
`define SCC_TRIG_SHORT 2'h1
`define SCC_TRIG_LONG 2'h2

// fault_status_general positions
`define SCC_G_DONE_BIT 15
`define SCC_G_ABORT_BIT 14
`define SCC_G_ACTIVE_BIT 13
`define SCC_G_HOST_BIT 12
`define SCC_G_OTP_BIT 11
`define SCC_G_LOW_BIT 10
`define SCC_G_HIGH_BIT 9
`define SCC_G_CUTOFF_BIT 8
`define SCC_G_CH_STRIDE 4
`define SCC_G_TOUT_BIT 3
`define SCC_G_CONFLICT_BIT 2
`define SCC_G_LATE_BIT 1
`define SCC_G_SYNCLOW_BIT 0
`define SCC_G_ROC_MASK 16'hD4FF

// fault_status_lines positions; channel n sits at n * CH_STRIDE
`define SCC_L_CH_STRIDE 8
`define SCC_L_BATT_BIT 4
`define SCC_L_LOW_BIT 0
`define SCC_L_ROC_MASK 16'hF8F8
`define SCC_L_ENCLR_MASK 16'h0606
`define SCC_L_XTEST_MASK 16'h1111

// sync pin timeout
`define SCC_SYNC_TOUT_US 100
`define SCC_CLK_PERIOD_NS 10

`endif

// [scc_pkg.sv]
// Purpose: types of the sensor channel control and status register group
// Assumes: two channels, index 0 is channel 1
// Notes: the whole block state is one packed struct
package scc_pkg;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] gen;
    logic [15:0] lines;
    logic [1:0] xlow;
    logic [1:0] pend;
    logic [1:0][15:0] tcnt;
    logic [1:0] sreq;
    logic [1:0] slong;
    logic [1:0] sbuf;
    logic [15:0] rdata;
    logic rvalid;
    logic fsum;
    logic regon;
  } scc_state_t;

endpackage

// [scc_sensor_channel_control_status.sv]
// Purpose: channel control, no-operation and two fault status registers
// Assumes: register access port is fed by the host-port frame logic,
//   one access per cycle, read data answered one cycle later
// Notes: index 0 of every two-bit vector is channel 1, index 1 channel 2
// Operation
// - channel control bit 10 enables the supply pre-regulator; resets to 1
// - channel 2 trigger bits 9:8: 01 short pulse, 10 long, others none
// - trigger field ignored, no pulse, while that channel's line is off
// - channel 1 trigger bits 4:3 same codes; acted on once per write
// - with upstream buffer in use, 01 and 10 equal; buffer sets length
// - allow bits 6 and 1 block pulses at 0, only in synchronous mode
// - enable bits 5 and 0 switch the sensor line off or on
// - no-operation write changes nothing; its read returns global status
// - both fault registers latch events and clear on read, listed exceptions
// - general bit 15 test done, 14 test aborted latched; 13 running live
// - general bit 12 set on any host-port fault
// - general bit 11 shows trimming checksum error live, unlatched
// - general bit 10 supply low latched; bit 9 supply high live
// - bit 8 latches on supply cutoff; cleared only by writing bit 10 to 0
// - sync pin held over 100 us in pin-driven pulse sets timeout flag
// - buffer write while buffer pending sets that channel's conflict flag
// - missing, delayed or weak sync pulse sets that channel's late flag
// - pulse amplitude low beyond filter time sets sync low flag
// - line register holds eight flags per channel, ch2 high byte
// - ground short and overheat flags clear only on line enable 0 write
// - during crosstest battery short and line low stay out of summary
// - line low bit live, but latched ground test result during crosstest
// - buffer pending stays 1 while data awaits sending, 0 once drained
`timescale 1ns/100ps
`include "scc_cfg.svh"
`default_nettype none

module scc_sensor_channel_control_status
  import scc_pkg::*;
#(
  parameter int unsigned SYNC_TOUT_CYCLES = (`SCC_SYNC_TOUT_US * 1000) / `SCC_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register access
  input wire logic acc_wr_i,
  input wire logic acc_rd_i,
  input wire logic [5:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  output logic [15:0] acc_rdata_o,
  output logic acc_rvalid_o,
  // channel mode
  input wire logic [1:0] sync_mode_i,
  input wire logic [1:0] use_buffer_i,
  input wire logic [1:0] sync_pin_source_i,
  input wire logic [1:0] sync_pin_i,
  // upstream buffer
  input wire logic [1:0] buffer_write_i,
  input wire logic [1:0] buffer_commit_i,
  input wire logic [1:0] buffer_drained_i,
  output logic [1:0] upstream_buffer_pending_o,
  // general fault events and levels
  input wire logic crosstest_done_i,
  input wire logic crosstest_aborted_i,
  input wire logic crosstest_active_i,
  input wire logic host_port_fault_i,
  input wire logic otp_crc_error_i,
  input wire logic supply_low_i,
  input wire logic supply_high_i,
  input wire logic supply_cutoff_i,
  input wire logic [1:0] sync_late_i,
  input wire logic [1:0] sync_low_i,
  // line fault events and levels
  input wire logic [15:0] line_fault_i,
  input wire logic [1:0] line_low_i,
  input wire logic [1:0] crosstest_ground_i,
  // control outputs
  output logic [1:0] line_enable_o,
  output logic supply_regulator_on_o,
  output logic [1:0] sync_request_o,
  output logic [1:0] sync_long_o,
  output logic [1:0] sync_len_from_buffer_o,
  output logic global_fault_summary_o
);

  localparam logic [15:0] TOUT_LAST = 16'(SYNC_TOUT_CYCLES - 1);

  scc_state_t s_reg;
  scc_state_t s_next;

  logic wr_ctrl;
  logic rd_gen;
  logic rd_lines;
  logic [15:0] gen_evt;
  logic [15:0] gen_view;
  logic [15:0] lines_view;
  logic [15:0] lines_clr;
  logic [1:0] tout_hit;

  assign wr_ctrl = acc_wr_i && (acc_addr_i == `SCC_OFS_CHANNEL_CONTROL);
  assign rd_gen = acc_rd_i && (acc_addr_i == `SCC_OFS_FAULT_GENERAL);
  assign rd_lines = acc_rd_i && (acc_addr_i == `SCC_OFS_FAULT_LINES);

  always_comb begin
    int ch;
    logic [1:0] code;
    logic [15:0] summ;
    ch = 0;
    s_next = s_reg;
    gen_evt = 16'h0000;
    lines_clr = 16'h0000;
    tout_hit = 2'b00;
    summ = 16'h0000;
    code = 2'b00;
    s_next.sreq = 2'b00;

    // live bits are merged only into the read view, never stored
    gen_view = s_reg.gen;
    gen_view[`SCC_G_ACTIVE_BIT] = crosstest_active_i;
    gen_view[`SCC_G_OTP_BIT] = otp_crc_error_i;
    gen_view[`SCC_G_HIGH_BIT] = supply_high_i;
    lines_view = s_reg.lines;

    gen_evt[`SCC_G_DONE_BIT] = crosstest_done_i;
    gen_evt[`SCC_G_ABORT_BIT] = crosstest_aborted_i;
    gen_evt[`SCC_G_HOST_BIT] = host_port_fault_i;
    gen_evt[`SCC_G_LOW_BIT] = supply_low_i;
    gen_evt[`SCC_G_CUTOFF_BIT] = supply_cutoff_i;

    for (ch = 0; ch < 2; ch++) begin
      // pin timeout counter runs only while a pin-driven pulse holds the pin
      if (sync_pin_source_i[ch] && sync_pin_i[ch]) begin
        if (s_reg.tcnt[ch] == TOUT_LAST) begin
          tout_hit[ch] = 1'b1;
        end else begin
          s_next.tcnt[ch] = s_reg.tcnt[ch] + 16'h0001;
        end
      end else begin
        s_next.tcnt[ch] = 16'h0000;
      end
      gen_evt[ch * `SCC_G_CH_STRIDE + `SCC_G_TOUT_BIT] = tout_hit[ch];
      gen_evt[ch * `SCC_G_CH_STRIDE + `SCC_G_CONFLICT_BIT] =
        buffer_write_i[ch] && s_reg.pend[ch];
      gen_evt[ch * `SCC_G_CH_STRIDE + `SCC_G_LATE_BIT] = sync_late_i[ch];
      gen_evt[ch * `SCC_G_CH_STRIDE + `SCC_G_SYNCLOW_BIT] = sync_low_i[ch];

      // pending: commit beats drain so a fresh load is never dropped
      if (buffer_commit_i[ch]) begin
        s_next.pend[ch] = 1'b1;
      end else if (buffer_drained_i[ch]) begin
        s_next.pend[ch] = 1'b0;
      end

      // line low: live, or the latched ground test result while testing
      lines_view[ch * `SCC_L_CH_STRIDE + `SCC_L_LOW_BIT] =
        crosstest_active_i ? s_reg.xlow[ch] : line_low_i[ch];
      if (rd_lines) begin
        s_next.xlow[ch] = 1'b0;
      end
      if (crosstest_ground_i[ch]) begin
        s_next.xlow[ch] = 1'b1;
      end

      // ground short and overheat clear on a write of line enable 0
      if (wr_ctrl &&
          !acc_wdata_i[ch * `SCC_CTRL_CH_STRIDE + `SCC_CTRL_EN_BIT]) begin
        lines_clr[ch * `SCC_L_CH_STRIDE +: `SCC_L_CH_STRIDE] =
          8'(`SCC_L_ENCLR_MASK >> (ch * `SCC_L_CH_STRIDE));
      end
    end

    // read clears latched bits; new events are ORed in after, so they win
    if (rd_gen) begin
      s_next.gen = s_reg.gen & ~`SCC_G_ROC_MASK;
    end
    if (wr_ctrl && !acc_wdata_i[`SCC_CTRL_REG_EN_BIT]) begin
      s_next.gen[`SCC_G_CUTOFF_BIT] = 1'b0;
    end
    s_next.gen = (s_next.gen | gen_evt) & (`SCC_G_ROC_MASK | 16'h0100);

    if (rd_lines) begin
      lines_clr = lines_clr | `SCC_L_ROC_MASK;
    end
    // low bits are live or held in xlow, so they are never stored here
    s_next.lines = ((s_reg.lines & ~lines_clr) | line_fault_i) &
      ~(`SCC_L_XTEST_MASK & 16'h0F0F);

    // channel control write and one-shot trigger evaluation
    if (wr_ctrl) begin
      s_next.ctrl = acc_wdata_i & `SCC_CTRL_RW_MASK;
      for (ch = 0; ch < 2; ch++) begin
        code = acc_wdata_i[ch * `SCC_CTRL_CH_STRIDE + `SCC_CTRL_TRIG_LSB +: 2];
        if (acc_wdata_i[ch * `SCC_CTRL_CH_STRIDE + `SCC_CTRL_EN_BIT] &&
            (code == `SCC_TRIG_SHORT || code == `SCC_TRIG_LONG) &&
            (!sync_mode_i[ch] ||
             acc_wdata_i[ch * `SCC_CTRL_CH_STRIDE + `SCC_CTRL_ALLOW_BIT])) begin
          s_next.sreq[ch] = 1'b1;
          s_next.sbuf[ch] = use_buffer_i[ch];
          s_next.slong[ch] = !use_buffer_i[ch] && (code == `SCC_TRIG_LONG);
        end
      end
    end

    // summary: battery short and line low held back during crosstest
    summ = lines_view;
    if (crosstest_active_i) begin
      summ = summ & ~`SCC_L_XTEST_MASK;
    end
    s_next.fsum = |summ;
    s_next.regon = s_reg.ctrl[`SCC_CTRL_REG_EN_BIT] &&
      !s_reg.gen[`SCC_G_CUTOFF_BIT];

    // read answer built from state before this cycle's clear
    s_next.rvalid = acc_rd_i;
    s_next.rdata = 16'h0000;
    if (acc_rd_i) begin
      if (acc_addr_i == `SCC_OFS_CHANNEL_CONTROL) begin
        s_next.rdata = s_reg.ctrl;
      end else if (acc_addr_i == `SCC_OFS_NO_OPERATION) begin
        s_next.rdata = {14'h0000, s_reg.fsum, |gen_view};
      end else if (acc_addr_i == `SCC_OFS_FAULT_GENERAL) begin
        s_next.rdata = gen_view;
      end else if (acc_addr_i == `SCC_OFS_FAULT_LINES) begin
        s_next.rdata = lines_view;
      end
    end

    if (rst_i) begin
      s_next = '0;
      s_next.ctrl = `SCC_RST_CHANNEL_CONTROL;
      s_next.regon = 1'b1;
    end
  end

  // a no-operation write has no decode here at all, so it cannot alter state
  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign acc_rdata_o = s_reg.rdata;
  assign acc_rvalid_o = s_reg.rvalid;
  assign upstream_buffer_pending_o = s_reg.pend;
  assign line_enable_o = {s_reg.ctrl[`SCC_CTRL_CH_STRIDE + `SCC_CTRL_EN_BIT],
                          s_reg.ctrl[`SCC_CTRL_EN_BIT]};
  assign supply_regulator_on_o = s_reg.regon;
  assign sync_request_o = s_reg.sreq;
  assign sync_long_o = s_reg.slong;
  assign sync_len_from_buffer_o = s_reg.sbuf;
  assign global_fault_summary_o = s_reg.fsum;

  // checks
  sequence s_wr_ch2_short;
    acc_wr_i && acc_addr_i == `SCC_OFS_CHANNEL_CONTROL && acc_wdata_i[5] &&
      acc_wdata_i[9:8] == 2'h1 && !use_buffer_i[1] && !sync_mode_i[1];
  endsequence

  sequence s_one_short_ch2;
    (sync_request_o[1] && !sync_long_o[1]) ##1 !sync_request_o[1];
  endsequence

  property p_ch2_short_once;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_ch2_short ##1 !wr_ctrl |-> s_one_short_ch2;
  endproperty
  a_ch2_short_once: assert property (p_ch2_short_once)
    else $error("channel 2 short trigger not a single short pulse");

  property p_line_off_no_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && !acc_wdata_i[0] |=> !sync_request_o[0];
  endproperty
  a_line_off_no_pulse: assert property (p_line_off_no_pulse)
    else $error("sync pulse issued with line off");

  property p_buffer_length;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && acc_wdata_i[0] && acc_wdata_i[4:3] == 2'h2 && use_buffer_i[0] &&
        !sync_mode_i[0] |=> sync_request_o[0] && sync_len_from_buffer_o[0] &&
        !sync_long_o[0];
  endproperty
  a_buffer_length: assert property (p_buffer_length)
    else $error("buffer length not taken from buffer");

  property p_mask_blocks;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && sync_mode_i[1] && !acc_wdata_i[6] |=> !sync_request_o[1];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked channel issued sync pulse");

  property p_regulator_off;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && !acc_wdata_i[10] |=> ##1 !supply_regulator_on_o;
  endproperty
  a_regulator_off: assert property (p_regulator_off)
    else $error("regulator stayed on after disable write");

  property p_cutoff_survives_read;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.gen[8] && rd_gen && !wr_ctrl |=> s_reg.gen[8];
  endproperty
  a_cutoff_survives_read: assert property (p_cutoff_survives_read)
    else $error("cutoff flag cleared by a read");

  property p_timeout_flag;
    @(posedge clk_i) disable iff (rst_i)
      sync_pin_source_i[0] && sync_pin_i[0] && s_reg.tcnt[0] == TOUT_LAST
        |=> s_reg.gen[3];
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("pin timeout flag missing");

  property p_set_beats_clear;
    @(posedge clk_i) disable iff (rst_i)
      rd_gen && host_port_fault_i |=> s_reg.gen[12];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("host fault lost on clearing read");

  property p_ground_short_kept;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.lines[2] && rd_lines && !wr_ctrl |=> s_reg.lines[2];
  endproperty
  a_ground_short_kept: assert property (p_ground_short_kept)
    else $error("ground short cleared by a read");

  property p_summary_masked;
    @(posedge clk_i) disable iff (rst_i)
      crosstest_active_i && (s_reg.lines & ~16'h1111) == 16'h0000 |=>
        !global_fault_summary_o;
  endproperty
  a_summary_masked: assert property (p_summary_masked)
    else $error("masked flags reached the summary");

  property p_pending_set;
    @(posedge clk_i) disable iff (rst_i)
      buffer_commit_i[1] |=> upstream_buffer_pending_o[1];
  endproperty
  a_pending_set: assert property (p_pending_set)
    else $error("buffer pending not raised on commit");

  property p_ch1_long;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && acc_wdata_i[0] && acc_wdata_i[4:3] == 2'h2 && !use_buffer_i[0] &&
        !sync_mode_i[0] |=> sync_request_o[0] && sync_long_o[0] &&
        !sync_len_from_buffer_o[0];
  endproperty
  a_ch1_long: assert property (p_ch1_long)
    else $error("channel 1 long trigger not a long pulse");

  property p_no_code_no_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && (acc_wdata_i[9:8] == 2'h0 || acc_wdata_i[9:8] == 2'h3) |=>
        !sync_request_o[1];
  endproperty
  a_no_code_no_pulse: assert property (p_no_code_no_pulse)
    else $error("channel 2 pulse without a valid code");

  property p_read_answer;
    @(posedge clk_i) disable iff (rst_i)
      acc_rd_i |=> acc_rvalid_o;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read without an answer");

  property p_conflict_flag;
    @(posedge clk_i) disable iff (rst_i)
      buffer_write_i[0] && upstream_buffer_pending_o[0] |=> s_reg.gen[2];
  endproperty
  a_conflict_flag: assert property (p_conflict_flag)
    else $error("buffer write conflict not flagged");

  property p_ground_short_cleared;
    @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && !acc_wdata_i[0] && !line_fault_i[2] |=> !s_reg.lines[2];
  endproperty
  a_ground_short_cleared: assert property (p_ground_short_cleared)
    else $error("ground short kept after line enable 0 write");

  // outside a crosstest the read shows the level at its own edge
  property p_low_live;
    @(posedge clk_i) disable iff (rst_i)
      rd_lines && !crosstest_active_i |=> acc_rdata_o[0] == $past(line_low_i[0]);
  endproperty
  a_low_live: assert property (p_low_live)
    else $error("line low bit not live outside crosstest");

endmodule // scc_sensor_channel_control_status

`default_nettype wire

// [scc_host_model.sv]
// Purpose: host side of the register access port
// Assumes: one access per cycle, inputs change on the falling edge
// Notes: read data is judged by the bench, not here
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  // clock
  input wire logic clk_i,
  // register access
  output logic acc_wr_o,
  output logic acc_rd_o,
  output logic [5:0] acc_addr_o,
  output logic [15:0] acc_wdata_o
);
  initial begin
    acc_wr_o = 1'b0;
    acc_rd_o = 1'b0;
    acc_addr_o = 6'h00;
    acc_wdata_o = 16'h0000;
  end
  // strobe lasts one cycle; stale address and data are inverted after it
  task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    acc_wr_o = wr;
    acc_rd_o = ~wr;
    acc_addr_o = a;
    acc_wdata_o = d;
    @(negedge clk_i);
    acc_wr_o = 1'b0;
    acc_rd_o = 1'b0;
    acc_addr_o = ~a;
    acc_wdata_o = ~d;
  endtask
endmodule // scc_host_model
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench of the channel control and status group
// Assumes: pin timeout shortened to 8 cycles
// Notes: read data and trigger results are matched through queues
`timescale 1ns/100ps
`include "scc_cfg.svh"
`default_nettype none
module tb_top;
  import scc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic acc_wr_i, acc_rd_i, acc_rvalid_o, supply_regulator_on_o, global_fault_summary_o;
  logic [5:0] acc_addr_i;
  logic [15:0] acc_wdata_i, acc_rdata_o;
  logic [15:0] gen_ev = 16'h0000;
  logic [15:0] line_fault_i = 16'h0000;
  logic [5:0] buf_ev = 6'h00;
  logic [1:0] sync_mode_i = 2'h0, use_buffer_i = 2'h0, sync_pin_source_i = 2'h0;
  logic [1:0] sync_pin_i = 2'h0, line_low_i = 2'h0, crosstest_ground_i = 2'h0;
  logic [1:0] upstream_buffer_pending_o, line_enable_o, sync_request_o;
  logic [1:0] sync_long_o, sync_len_from_buffer_o;
  logic wr_d = 1'b0;
  logic [15:0] rq[$];
  logic [5:0] sq[$];
  logic [15:0] seed = 16'hDE0A;
  int fail_count = 0;
  int n_checks = 0;
  int lb[8] = '{15, 14, 12, 10, 5, 4, 1, 0};

  always #5 clk_i = ~clk_i;

  scc_host_model host (.clk_i(clk_i), .acc_wr_o(acc_wr_i), .acc_rd_o(acc_rd_i),
    .acc_addr_o(acc_addr_i), .acc_wdata_o(acc_wdata_i));

  scc_sensor_channel_control_status #(.SYNC_TOUT_CYCLES(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i),
    .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i), .acc_rdata_o(acc_rdata_o),
    .acc_rvalid_o(acc_rvalid_o), .sync_mode_i(sync_mode_i), .use_buffer_i(use_buffer_i),
    .sync_pin_source_i(sync_pin_source_i), .sync_pin_i(sync_pin_i),
    .buffer_write_i(buf_ev[1:0]), .buffer_commit_i(buf_ev[3:2]),
    .buffer_drained_i(buf_ev[5:4]), .upstream_buffer_pending_o(upstream_buffer_pending_o),
    .crosstest_done_i(gen_ev[15]), .crosstest_aborted_i(gen_ev[14]),
    .crosstest_active_i(gen_ev[13]), .host_port_fault_i(gen_ev[12]),
    .otp_crc_error_i(gen_ev[11]), .supply_low_i(gen_ev[10]), .supply_high_i(gen_ev[9]),
    .supply_cutoff_i(gen_ev[8]), .sync_late_i({gen_ev[5], gen_ev[1]}),
    .sync_low_i({gen_ev[4], gen_ev[0]}), .line_fault_i(line_fault_i),
    .line_low_i(line_low_i), .crosstest_ground_i(crosstest_ground_i),
    .line_enable_o(line_enable_o), .supply_regulator_on_o(supply_regulator_on_o),
    .sync_request_o(sync_request_o), .sync_long_o(sync_long_o),
    .sync_len_from_buffer_o(sync_len_from_buffer_o),
    .global_fault_summary_o(global_fault_summary_o));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    rq.push_back(e);
    host.access(1'b0, a, 16'h0000);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [5:0] e;
    logic [1:0] code;
    e = 6'h00;
    for (int c = 0; c < 2; c++) begin
      code = d[5*c+3 +: 2];
      e[c] = a == 6'h02 && d[5*c] && (code == 2'h1 || code == 2'h2)
        && (!sync_mode_i[c] || d[5*c+1]);
      e[2+c] = e[c] && code == 2'h2 && !use_buffer_i[c];
      e[4+c] = e[c] && use_buffer_i[c];
    end
    sq.push_back(e);
    host.access(1'b1, a, d);
  endtask

  task automatic drive(input int k, input logic [15:0] v);
    case (k)
      0: gen_ev = v;
      1: line_fault_i = v;
      2: buf_ev = v[5:0];
      default: crosstest_ground_i = v[1:0];
    endcase
  endtask

  task automatic pulse(input int k, input logic [15:0] v);
    @(negedge clk_i);
    drive(k, v);
    @(negedge clk_i);
    drive(k, 16'h0000);
  endtask

  // results are taken where they settle, half a cycle after the edge
  always @(posedge clk_i) wr_d <= acc_wr_i;
  always @(negedge clk_i) begin
    if (acc_rvalid_o === 1'b1) begin
      if (rq.size() == 0) rq.push_back(~acc_rdata_o);
      chk(acc_rdata_o, rq.pop_front());
    end
    if (wr_d) chk({10'h000, sync_len_from_buffer_o & sync_request_o,
      sync_long_o & sync_request_o, sync_request_o}, {10'h000, sq.pop_front()});
    else if (!rst_i) chk({14'h0000, sync_request_o}, 16'h0000);
  end

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk({13'h0000, supply_regulator_on_o, line_enable_o}, 16'h0004);
    rd(6'h02, `SCC_RST_CHANNEL_CONTROL);
    rd(6'h03, 16'h0000);
    rd(6'h3F, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      {use_buffer_i, sync_mode_i} = seed[3:0];
      seed = lfsr(seed);
      wr(6'h02, seed);
      rd(6'h02, seed & `SCC_CTRL_RW_MASK);
      chk({13'h0000, supply_regulator_on_o, line_enable_o},
        {13'h0000, seed[10], seed[5], seed[0]});
    end
    // every code on both channels, out of sync mode and masked in sync mode
    for (int k = 0; k < 8; k++) begin
      sync_mode_i = {k[2], k[2]};
      wr(6'h02, 16'h0421 | (16'(k[1:0]) << 8) | (16'(k[1:0]) << 3));
    end
    wr(6'h03, 16'hFFFF);
    rd(6'h02, 16'h0421 | 16'h0300 | 16'h0018);
    wr(6'h02, 16'h0421);
    for (int i = 0; i < 8; i++) begin
      pulse(0, 16'h0001 << lb[i]);
      rd(6'h04, 16'h0001 << lb[i]);
      rd(6'h04, 16'h0000);
    end
    pulse(0, 16'h1000);
    rd(6'h03, 16'h0001);
    rd(6'h04, 16'h1000);
    gen_ev = 16'h2A00;
    rd(6'h04, 16'h2A00);
    rd(6'h04, 16'h2A00);
    gen_ev = 16'h0000;
    rd(6'h04, 16'h0000);
    fork
      rd(6'h04, 16'h0000);
      pulse(0, 16'h1000);
    join
    rd(6'h04, 16'h1000);
    pulse(0, 16'h0100);
    rd(6'h04, 16'h0100);
    rd(6'h04, 16'h0100);
    chk({15'h0000, supply_regulator_on_o}, 16'h0000);
    wr(6'h02, 16'h0021);
    wr(6'h02, 16'h0421);
    rd(6'h04, 16'h0000);
    chk({15'h0000, supply_regulator_on_o}, 16'h0001);
    for (int c = 0; c < 2; c++) begin
      sync_pin_source_i = 2'h1 << c;
      sync_pin_i = 2'h1 << c;
      // one cycle short of the limit, then exactly at it
      repeat (7) @(negedge clk_i);
      sync_pin_i = 2'h0;
      rd(6'h04, 16'h0000);
      sync_pin_i = 2'h1 << c;
      repeat (8) @(negedge clk_i);
      sync_pin_i = 2'h0;
      rd(6'h04, 16'h0008 << (4*c));
      pulse(2, 16'h0001 << c);
      pulse(2, 16'h0004 << c);
      chk({14'h0000, upstream_buffer_pending_o}, 16'h0001 << c);
      pulse(2, 16'h0001 << c);
      pulse(2, 16'h0010 << c);
      chk({14'h0000, upstream_buffer_pending_o}, 16'h0000);
      rd(6'h04, 16'h0004 << (4*c));
    end
    for (int b = 1; b < 16; b++) begin
      if (b != 8) begin
        pulse(1, 16'h0001 << b);
        rd(6'h05, 16'h0001 << b);
        if (`SCC_L_ENCLR_MASK & (16'h0001 << b)) begin
          rd(6'h05, 16'h0001 << b);
          chk({15'h0000, global_fault_summary_o}, 16'h0001);
          wr(6'h02, 16'h0421 & ~(16'h0001 << (5*(b/8))));
          wr(6'h02, 16'h0421);
        end
        rd(6'h05, 16'h0000);
      end
    end
    line_low_i = 2'h3;
    rd(6'h05, 16'h0101);
    chk({15'h0000, global_fault_summary_o}, 16'h0001);
    gen_ev = 16'h2000;
    pulse(1, 16'h1010);
    repeat (2) @(negedge clk_i);
    chk({15'h0000, global_fault_summary_o}, 16'h0000);
    rd(6'h05, 16'h1010);
    pulse(3, 16'h0003);
    rd(6'h05, 16'h0101);
    rd(6'h05, 16'h0000);
    gen_ev = 16'h0000;
    line_low_i = 2'h0;
    repeat (3) @(negedge clk_i);
    // a reset in mid-run must bring back the reset view
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk({13'h0000, supply_regulator_on_o, line_enable_o}, 16'h0004);
    rd(6'h02, `SCC_RST_CHANNEL_CONTROL);
    rd(6'h04, 16'h0000);
    rd(6'h05, 16'h0000);
    repeat (3) @(negedge clk_i);
    chk(16'(rq.size() + sq.size()), 16'h0000);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
